// ---- i2t_consts.svh ----
// Register offsets, field positions and reset values of the two-wire target.
// Included by the target module and the bench; definitions only.
`ifndef I2T_CONSTS_SVH
`define I2T_CONSTS_SVH

`define I2T_OFF_RX_BUFFER 12'h000
`define I2T_OFF_TX_HOLDING 12'h004
`define I2T_OFF_BAUD_RELOAD 12'h008
`define I2T_OFF_BUS_CONTROL 12'h00c
`define I2T_OFF_BUS_STATUS 12'h010
`define I2T_OFF_OWN_ADDRESS 12'h014

// bus_control fields
`define I2T_CTL_ENABLE 15
`define I2T_CTL_RELEASE 12
`define I2T_CTL_WIDE 10

// bus_status fields; bits 5:0 are read-only
`define I2T_ST_RX_FULL 0
`define I2T_ST_TX_FULL 1
`define I2T_ST_READ_DIR 2
`define I2T_ST_START 3
`define I2T_ST_STOP 4
`define I2T_ST_MASTER_NACK 5
`define I2T_ST_OVERFLOW 6
`define I2T_ST_WIDE_MATCH 8
`define I2T_ST_RO_MASK 16'h003f

`define I2T_CTL_RESET 16'h1000
`define I2T_STATUS_RESET 16'h0000
`define I2T_BAUD_RESET 9'h000
`define I2T_ADDR_RESET 10'h000
`define I2T_WIDE_PREFIX 5'h1e

`endif

// ---- i2t_pkg.sv ----
// Types shared by the two-wire target.
// Assumes i2t_consts.svh for the numeric constants.
package i2t_pkg;

    typedef enum logic [2:0] {
        I2T_IDLE = 3'b000,
        I2T_ADDR1 = 3'b001,
        I2T_ADDR2 = 3'b010,
        I2T_RX = 3'b011,
        I2T_TX = 3'b100,
        I2T_ACK = 3'b101,
        I2T_MACK = 3'b110,
        I2T_HOLD = 3'b111
    } i2t_state_t;

    typedef enum logic [1:0] {
        I2T_AFTER_IDLE = 2'b00,
        I2T_AFTER_ADDR2 = 2'b01,
        I2T_AFTER_RX = 2'b10,
        I2T_AFTER_HOLD = 2'b11
    } i2t_after_t;

endpackage : i2t_pkg

// ---- i2t_target.sv ----
// Two-wire bus target with 7/10-bit addressing, reached over APB.
// Assumes scl_in/sda_in are already synchronous to pclk and pulled up outside.
//
// Behaviour
// - Control bit 10 selects 10-bit addressing when one, 7-bit when zero.
// - 7-bit: own bits 6:0 match shift bits 7:1; shift bit 0 is direction.
// - When enabled, wait idle for Start, then shift 8 address bits in.
// - Every incoming data bit is sampled on the rising clock edge.
// - Address match: acknowledge, event pulse on falling edge of ninth clock.
// - Matched 7-bit address byte is copied into rx_buffer and receive-full is set.
// - Direction one: transmit mode, acknowledge, hold clock low for software.
// - Held clock released only when software sets release bit; then 8 bits out.
// - Transmit data changes on falling clock edges, stable while clock high.
// - Transmit: event pulse on ninth falling edge whether acknowledged or not.
// - Direction zero: receive 8 bits, buffer and acknowledge when room allows.
// - Buffer still full: no acknowledge, event pulse, buffer left unchanged.
// - Overflow set and buffer empty: buffer updated but not acknowledged.
// - 10-bit first byte: bits 7:3 equal 11110, bits 2:1 equal own 9:8.
// - First byte match writing: event pulse, clear wide match, partial match.
// - First byte mismatch, or read direction without wide match set: clear wide match, go idle.
// - Second byte vs own 7:0: match sets wide match, else clear and idle.
// - Reception double-buffered with event pulse; transmit single-buffered.
// - Low 6 status bits read-only, remaining status bits read and write.
// - 9-bit baud_reload reloads a down-counting rate generator on pclk.
// - After Repeated Start in 10-bit mode only first byte must match.
`timescale 1ns/10ps
`include "i2t_consts.svh"

module i2t_target
    import i2t_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic target_event,
    output logic baud_tick
);

    i2t_state_t state;
    i2t_after_t after_ack;
    logic [7:0] rx_buffer;
    logic [7:0] tx_holding;
    logic [8:0] baud_reload;
    logic [15:0] bus_control;
    logic [15:0] bus_status;
    logic [9:0] own_address;
    logic [7:0] rx_shift_register;
    logic [7:0] tx_shift;
    logic [3:0] bit_cnt;
    logic [8:0] baud_cnt;
    logic scl_prev;
    logic sda_prev;
    logic next_ack;
    logic next_event;
    logic hw_clear_release;

    wire logic acc = psel & penable & pready;
    wire logic wr = acc & pwrite;
    wire logic rd = acc & ~pwrite;
    wire logic enabled = bus_control[`I2T_CTL_ENABLE];
    wire logic scl_rise = scl_in & ~scl_prev;
    wire logic scl_fall = ~scl_in & scl_prev;
    wire logic start_seen = scl_in & scl_prev & sda_prev & ~sda_in;
    wire logic stop_seen = scl_in & scl_prev & ~sda_prev & sda_in;
    wire logic rx_full = bus_status[`I2T_ST_RX_FULL];
    wire logic overflow = bus_status[`I2T_ST_OVERFLOW];
    wire logic wide_match = bus_status[`I2T_ST_WIDE_MATCH];
    wire logic match7 = rx_shift_register[7:1] == own_address[6:0];
    wire logic match_hi = rx_shift_register[7:3] == `I2T_WIDE_PREFIX
        && rx_shift_register[2:1] == own_address[9:8];
    wire logic byte_done = scl_fall && bit_cnt == 4'd8;

    // APB answers one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && penable && !pready) begin
                case (paddr)
                    `I2T_OFF_RX_BUFFER: prdata <= {24'h000000, rx_buffer};
                    `I2T_OFF_TX_HOLDING: prdata <= 32'h00000000;
                    `I2T_OFF_BAUD_RELOAD: prdata <= {23'h000000, baud_reload};
                    `I2T_OFF_BUS_CONTROL: prdata <= {16'h0000, bus_control};
                    `I2T_OFF_BUS_STATUS: prdata <= {16'h0000, bus_status};
                    `I2T_OFF_OWN_ADDRESS: prdata <= {22'h000000, own_address};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_reload <= `I2T_BAUD_RESET;
            own_address <= `I2T_ADDR_RESET;
            tx_holding <= 8'h00;
        end else if (wr) begin
            if (paddr == `I2T_OFF_BAUD_RELOAD) baud_reload <= pwdata[8:0];
            if (paddr == `I2T_OFF_OWN_ADDRESS) own_address <= pwdata[9:0];
            if (paddr == `I2T_OFF_TX_HOLDING) tx_holding <= pwdata[7:0];
        end
    end

    // Software setting the release bit wins over the automatic clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_control <= `I2T_CTL_RESET;
        end else begin
            if (hw_clear_release) bus_control[`I2T_CTL_RELEASE] <= 1'b0;
            if (wr && paddr == `I2T_OFF_BUS_CONTROL) bus_control <= pwdata[15:0];
        end
    end

    // Down counter reloaded from baud_reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt <= 9'h000;
            baud_tick <= 1'b0;
        end else if (!enabled) begin
            baud_cnt <= baud_reload;
            baud_tick <= 1'b0;
        end else if (baud_cnt == 9'h000) begin
            baud_cnt <= baud_reload;
            baud_tick <= 1'b1;
        end else begin
            baud_cnt <= baud_cnt - 9'h001;
            baud_tick <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_in;
            sda_prev <= sda_in;
        end
    end

    // Decision on the byte just shifted in, taken at the eighth falling edge
    always_comb begin
        next_ack = 1'b0;
        case (state)
            I2T_ADDR1: begin
                if (!bus_control[`I2T_CTL_WIDE]) begin
                    next_ack = match7;
                end else begin
                    next_ack = match_hi && (!rx_shift_register[0] || wide_match);
                end
            end
            I2T_ADDR2: next_ack = rx_shift_register == own_address[7:0];
            I2T_RX: next_ack = !rx_full && !overflow;
            default: next_ack = 1'b0;
        endcase
    end

    always_comb begin
        next_event = 1'b0;
        if (state == I2T_ACK && scl_fall && after_ack != I2T_AFTER_IDLE) begin
            next_event = 1'b1;
        end
        if (state == I2T_MACK && scl_fall) begin
            next_event = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_event <= 1'b0;
        end else begin
            target_event <= next_event;
        end
    end

    // Status flags: hardware sets win over software clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_status <= `I2T_STATUS_RESET;
            rx_buffer <= 8'h00;
        end else begin
            if (wr && paddr == `I2T_OFF_BUS_STATUS) begin
                bus_status <= (bus_status & `I2T_ST_RO_MASK)
                    | (pwdata[15:0] & ~`I2T_ST_RO_MASK);
            end
            if (rd && paddr == `I2T_OFF_RX_BUFFER) bus_status[`I2T_ST_RX_FULL] <= 1'b0;
            if (wr && paddr == `I2T_OFF_TX_HOLDING) bus_status[`I2T_ST_TX_FULL] <= 1'b1;
            if (state == I2T_HOLD && bus_control[`I2T_CTL_RELEASE]) begin
                bus_status[`I2T_ST_TX_FULL] <= 1'b0;
            end
            if (start_seen) bus_status[`I2T_ST_START] <= 1'b1;
            if (stop_seen) bus_status[`I2T_ST_STOP] <= 1'b1;
            if (state == I2T_MACK && scl_rise) bus_status[`I2T_ST_MASTER_NACK] <= sda_in;
            if (byte_done) begin
                case (state)
                    I2T_ADDR1: begin
                        bus_status[`I2T_ST_START] <= 1'b0;
                        bus_status[`I2T_ST_STOP] <= 1'b0;
                        if (next_ack) begin
                            bus_status[`I2T_ST_READ_DIR] <= rx_shift_register[0];
                        end
                        if (next_ack && !bus_control[`I2T_CTL_WIDE]) begin
                            rx_buffer <= rx_shift_register;
                            bus_status[`I2T_ST_RX_FULL] <= 1'b1;
                        end
                        if (bus_control[`I2T_CTL_WIDE] && !(next_ack && rx_shift_register[0])) begin
                            bus_status[`I2T_ST_WIDE_MATCH] <= 1'b0;
                        end
                    end
                    I2T_ADDR2: begin
                        bus_status[`I2T_ST_WIDE_MATCH] <= next_ack;
                    end
                    I2T_RX: begin
                        if (!rx_full) begin
                            rx_buffer <= rx_shift_register;
                            bus_status[`I2T_ST_RX_FULL] <= 1'b1;
                        end else begin
                            bus_status[`I2T_ST_OVERFLOW] <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Bit-level sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= I2T_IDLE;
            after_ack <= I2T_AFTER_IDLE;
            bit_cnt <= 4'h0;
            rx_shift_register <= 8'h00;
            tx_shift <= 8'h00;
            sda_oe <= 1'b0;
            hw_clear_release <= 1'b0;
        end else if (!enabled) begin
            state <= I2T_IDLE;
            sda_oe <= 1'b0;
            hw_clear_release <= 1'b0;
        end else if (start_seen) begin
            state <= I2T_ADDR1;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
            hw_clear_release <= 1'b0;
        end else if (stop_seen) begin
            state <= I2T_IDLE;
            sda_oe <= 1'b0;
            hw_clear_release <= 1'b0;
        end else begin
            hw_clear_release <= 1'b0;
            case (state)
                I2T_IDLE: sda_oe <= 1'b0;
                I2T_ADDR1, I2T_ADDR2, I2T_RX: begin
                    if (scl_rise && bit_cnt < 4'd8) begin
                        rx_shift_register <= {rx_shift_register[6:0], sda_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        sda_oe <= next_ack;
                        bit_cnt <= 4'h0;
                        state <= I2T_ACK;
                        after_ack <= I2T_AFTER_IDLE;
                        if (state == I2T_RX) begin
                            after_ack <= I2T_AFTER_RX;
                        end else if (next_ack && state == I2T_ADDR1
                                     && rx_shift_register[0]) begin
                            after_ack <= I2T_AFTER_HOLD;
                        end else if (next_ack && state == I2T_ADDR1
                                     && bus_control[`I2T_CTL_WIDE]) begin
                            after_ack <= I2T_AFTER_ADDR2;
                        end else if (next_ack) begin
                            after_ack <= I2T_AFTER_RX;
                        end
                    end
                end
                I2T_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        case (after_ack)
                            I2T_AFTER_ADDR2: state <= I2T_ADDR2;
                            I2T_AFTER_RX: state <= I2T_RX;
                            I2T_AFTER_HOLD: begin
                                state <= I2T_HOLD;
                                hw_clear_release <= 1'b1;
                            end
                            default: state <= I2T_IDLE;
                        endcase
                    end
                end
                I2T_HOLD: begin
                    if (bus_control[`I2T_CTL_RELEASE] && !hw_clear_release) begin
                        tx_shift <= tx_holding;
                        sda_oe <= ~tx_holding[7];
                        bit_cnt <= 4'h0;
                        state <= I2T_TX;
                    end
                end
                I2T_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'd7) begin
                            sda_oe <= 1'b0;
                            state <= I2T_MACK;
                        end else begin
                            tx_shift <= {tx_shift[6:0], 1'b0};
                            sda_oe <= ~tx_shift[6];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                I2T_MACK: begin
                    if (scl_fall) begin
                        if (!bus_status[`I2T_ST_MASTER_NACK]) begin
                            state <= I2T_HOLD;
                            hw_clear_release <= 1'b1;
                        end else begin
                            state <= I2T_IDLE;
                        end
                    end
                end
                default: state <= I2T_IDLE;
            endcase
        end
    end

    // Clock stretch while waiting for software in transmit mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_oe <= enabled && state == I2T_HOLD
                && (!bus_control[`I2T_CTL_RELEASE] || hw_clear_release);
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

endmodule : i2t_target

// ---- i2t_target_chk.sv ----
// Port-level checks of the two-wire target.
// Bound to i2t_target from the bench top; sees its ports only.
`timescale 1ns/10ps
module i2t_target_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic target_event
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer to access");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_refused; pslverr |-> pready && prdata == 32'h0; endproperty
    a_refused: assert property (p_refused) else $error("bad error answer");
    property p_open_drain; scl_out == 1'b0 && sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_event_pulse; target_event |=> !target_event; endproperty
    a_event_pulse: assert property (p_event_pulse) else $error("event held");
    property p_event_at_fall;
        $rose(target_event) |-> !$past(scl_in) && $past(scl_in, 2);
    endproperty
    a_event_at_fall: assert property (p_event_at_fall) else $error("event off clock low");
    // Data must stay put while the clock stays high
    property p_data_stable; scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe); endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved in clock high");
    property p_hold_low; $rose(scl_oe) |-> !$past(scl_in); endproperty
    a_hold_low: assert property (p_hold_low) else $error("hold began with clock high");
    property p_hold_kept; scl_oe && !psel && !$past(psel) |=> scl_oe; endproperty
    a_hold_kept: assert property (p_hold_kept) else $error("hold dropped unasked");
endmodule : i2t_target_chk

// ---- i2t_bus_master.sv ----
// Far-side bus controller model; pulls the two lines low or lets them go.
// Assumes the bench resolves wire levels with pull-ups.
`timescale 1ns/10ps
module i2t_bus_master (
    input wire logic pclk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n
    // One bit slot; waits while the target stretches the clock
    task automatic bit_io(input logic b, output logic r);
        int w;
        sda_low <= !b;
        wait_n(4);
        scl_low <= 1'b0;
        w = 0;
        while (scl !== 1'b1 && w < 4000) begin
            @(posedge pclk);
            w++;
        end
        wait_n(4);
        r = sda;
        scl_low <= 1'b1;
        wait_n(4);
    endtask : bit_io
    task automatic start();
        sda_low <= 1'b1;
        wait_n(4);
        scl_low <= 1'b1;
        wait_n(4);
    endtask : start
    // Repeated start, entered from the clock-low phase after a byte
    task automatic rep_start();
        sda_low <= 1'b0;
        wait_n(4);
        scl_low <= 1'b0;
        wait_n(4);
        start();
    endtask : rep_start
    task automatic stop();
        sda_low <= 1'b1;
        wait_n(4);
        scl_low <= 1'b0;
        wait_n(4);
        sda_low <= 1'b0;
        wait_n(4);
    endtask : stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : send_byte
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(!ack, r);
    endtask : recv_byte
endmodule : i2t_bus_master

// ---- tb_i2t_target.sv ----
// Bench for the two-wire target: APB register access and bus transfers.
// Uses i2t_bus_master on the lines and binds i2t_target_chk to the target.
`timescale 1ns/10ps
`include "i2t_consts.svh"
module tb_i2t_target;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ack, err;
    logic scl_out, scl_oe, sda_out, sda_oe, target_event, baud_tick, m_scl_low, m_sda_low;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] d;
    int failures = 0;
    int n_tests = 0;
    int n_ev = 0;
    int cycles = 0;
    int e0;
    // Open-drain lines with pull-ups
    wire scl = !((scl_oe && !scl_out) || m_scl_low);
    wire sda = !((sda_oe && !sda_out) || m_sda_low);
    i2t_target i2t_target_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out,
        .sda_oe, .target_event, .baud_tick);
    i2t_bus_master i2t_bus_master_inst (.pclk, .scl, .sda, .scl_low(m_scl_low),
        .sda_low(m_sda_low));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = !pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (target_event === 1'b1) begin
            n_ev++;
        end
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rdc
    task automatic txc(input logic [7:0] b, input logic e);
        i2t_bus_master_inst.send_byte(b, ack);
        chk(32'(ack), 32'(e));
    endtask : txc
    task automatic t_regs();
        int n;
        rdc(`I2T_OFF_BUS_CONTROL, 32'hffffffff, 32'h1000);
        apb(1'b0, 12'h018, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, `I2T_OFF_BUS_STATUS, 32'hffff);
        rdc(`I2T_OFF_BUS_STATUS, 32'h17f, 32'h140);
        apb(1'b1, `I2T_OFF_BUS_STATUS, 32'h0);
        apb(1'b1, `I2T_OFF_BAUD_RELOAD, 32'h4);
        apb(1'b1, `I2T_OFF_BUS_CONTROL, 32'h9000);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (baud_tick !== 1'b1 && n < 50);
        end
        chk(n, 5);
        apb(1'b1, `I2T_OFF_BUS_CONTROL, 32'h1000);
        $display("register test done");
    endtask : t_regs
    task automatic t_rx7();
        apb(1'b1, `I2T_OFF_OWN_ADDRESS, 32'h52);
        i2t_bus_master_inst.start();
        txc(8'ha4, 1'b0);
        i2t_bus_master_inst.stop();
        apb(1'b1, `I2T_OFF_BUS_CONTROL, 32'h9000);
        e0 = n_ev;
        i2t_bus_master_inst.start();
        txc(8'ha4, 1'b1);
        rdc(`I2T_OFF_RX_BUFFER, 32'hff, 32'ha4);
        txc(8'h3c, 1'b1);
        txc(8'h5a, 1'b0);
        rdc(`I2T_OFF_RX_BUFFER, 32'hff, 32'h3c);
        txc(8'h77, 1'b0);
        rdc(`I2T_OFF_RX_BUFFER, 32'hff, 32'h77);
        i2t_bus_master_inst.stop();
        chk(n_ev - e0, 4);
        i2t_bus_master_inst.start();
        txc(8'ha6, 1'b0);
        i2t_bus_master_inst.stop();
        apb(1'b1, `I2T_OFF_BUS_STATUS, 32'h0);
        $display("receive test done");
    endtask : t_rx7
    task automatic t_tx7();
        e0 = n_ev;
        i2t_bus_master_inst.start();
        txc(8'ha5, 1'b1);
        chk(32'(scl_oe), 32'h1);
        fork
            i2t_bus_master_inst.recv_byte(1'b0, d);
            begin
                apb(1'b1, `I2T_OFF_TX_HOLDING, 32'hc5);
                chk(32'(scl_oe), 32'h1);
                apb(1'b1, `I2T_OFF_BUS_CONTROL, 32'h9000);
            end
        join
        chk(32'(d), 32'hc5);
        i2t_bus_master_inst.stop();
        chk(n_ev - e0, 2);
        $display("transmit test done");
    endtask : t_tx7
    task automatic t_w10();
        apb(1'b1, `I2T_OFF_BUS_CONTROL, 32'h9400);
        apb(1'b1, `I2T_OFF_OWN_ADDRESS, 32'h2b7);
        apb(1'b1, `I2T_OFF_BUS_STATUS, 32'h100);
        e0 = n_ev;
        i2t_bus_master_inst.start();
        txc(8'hf4, 1'b1);
        rdc(`I2T_OFF_BUS_STATUS, 32'h100, 32'h0);
        txc(8'hb7, 1'b1);
        rdc(`I2T_OFF_BUS_STATUS, 32'h100, 32'h100);
        i2t_bus_master_inst.rep_start();
        txc(8'hf5, 1'b1);
        chk(32'(scl_oe), 32'h1);
        fork
            i2t_bus_master_inst.recv_byte(1'b0, d);
            apb(1'b1, `I2T_OFF_BUS_CONTROL, 32'h9400);
        join
        chk(32'(d), 32'hc5);
        i2t_bus_master_inst.stop();
        chk(n_ev - e0, 4);
        i2t_bus_master_inst.start();
        txc(8'hf2, 1'b0);
        i2t_bus_master_inst.stop();
        rdc(`I2T_OFF_BUS_STATUS, 32'h100, 32'h0);
        i2t_bus_master_inst.start();
        txc(8'hf4, 1'b1);
        txc(8'hb6, 1'b0);
        i2t_bus_master_inst.stop();
        $display("wide address test done");
    endtask : t_w10
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_rx7();
        t_tx7();
        t_w10();
        complete_run();
    end
endmodule : tb_i2t_target
bind i2t_target i2t_target_chk i2t_target_chk_inst (.pclk, .presetn, .psel, .penable, .prdata,
    .pready, .pslverr, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe, .target_event);
